// >>> hw/sbi_bus_port.sv
// external system bus port: sequences one access at a time to dram,
// boot memory, display or card, and makes the card clock and reset
// assumes requests come from logic on mclk; pin inputs are asynchronous
`timescale 1ns/10ps
`default_nettype none
module sbi_bus_port #(
	parameter int ROW_CYC = sbi_pkg::ROW_CYC,
	parameter int CAS_CYC = sbi_pkg::CAS_CYC,
	parameter int STROBE_CYC = sbi_pkg::STROBE_CYC,
	parameter int TIMEOUT_CYC = sbi_pkg::TIMEOUT_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// request side
	input wire logic req_valid,
	input wire sbi_pkg::sbi_req_t req,
	output logic req_ready,
	output logic resp_valid,
	output logic resp_error,
	output logic [sbi_pkg::DATA_W-1:0] resp_rdata,
	// card control
	input wire logic card_reset_req,
	output logic card_irq_req,
	// shared address and data pins
	output logic [sbi_pkg::ADDR_W-1:0] addr_out,
	input wire logic [sbi_pkg::DATA_W-1:0] data_in,
	output logic [sbi_pkg::DATA_W-1:0] data_out,
	output logic data_oe,
	// display and boot memory pins
	output logic display_select_n,
	output logic display_read_enable_n,
	output logic shared_write_strobe_n,
	input wire logic target_ready,
	output logic [sbi_pkg::CHIPS-1:0] boot_memory_select_n,
	output logic boot_memory_read_enable_n,
	// dram pins
	output logic [sbi_pkg::CHIPS-1:0] dram_row_strobe_n,
	output logic dram_upper_column_strobe_n,
	output logic dram_lower_column_strobe_n,
	output logic dram_write_enable_n,
	// card pins
	output logic card_clock,
	output logic card_high_byte_enable_n,
	output logic card_io_read_n,
	output logic card_io_write_n,
	output logic card_mem_read_n,
	output logic card_mem_write_n,
	input wire logic card_zero_wait_n,
	input wire logic card_irq,
	output logic card_reset_out
);
	localparam logic [sbi_pkg::CNT_W-1:0] ROW_LAST = sbi_pkg::CNT_W'(ROW_CYC - 1);
	localparam logic [sbi_pkg::CNT_W-1:0] CAS_LAST = sbi_pkg::CNT_W'(CAS_CYC - 1);
	localparam logic [sbi_pkg::CNT_W-1:0] STB_LAST = sbi_pkg::CNT_W'(STROBE_CYC - 1);
	localparam logic [sbi_pkg::CNT_W-1:0] TMO_LAST = sbi_pkg::CNT_W'(TIMEOUT_CYC - 1);
	localparam logic [4:0] CARD_LAST = 5'(sbi_pkg::CARD_DIV - 1);
	localparam logic [4:0] CARD_HI = 5'(sbi_pkg::CARD_HIGH);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ROW,
		ST_COL,
		ST_SETUP,
		ST_STROBE,
		ST_HOLD
	} sbi_state_t;
	////////////////////////////////////////////////////////////////////
	// pin input filtering
	logic ready_s, zero_wait_n_s;

	// [RQ19] interrupt request in
	sbi_pin_sync #(.W(3), .RESET_VAL(3'b010)) u_sync (
		.mclk(mclk),
		.rst(rst),
		.pin({target_ready, card_zero_wait_n, card_irq}),
		.level({ready_s, zero_wait_n_s, card_irq_req})
	);
	////////////////////////////////////////////////////////////////////
	// access sequencer
	sbi_state_t state, next_state;
	sbi_pkg::sbi_req_t cur, next_cur;
	logic [sbi_pkg::CNT_W-1:0] cnt, next_cnt;
	logic next_req_ready, next_resp_valid, next_resp_error;
	logic [sbi_pkg::DATA_W-1:0] next_rdata;
	logic go_on, timed_out;

	always_comb begin
		go_on = 1'b0;
		// [RQ6] display and card wait for ready
		if (cur.target == sbi_pkg::SBI_DISPLAY) begin
			go_on = ready_s;
		// [RQ18] zero wait ends card access
		end else if (cur.target == sbi_pkg::SBI_CARD_IO || cur.target == sbi_pkg::SBI_CARD_MEM) begin
			go_on = ready_s || !zero_wait_n_s;
		end else begin
			go_on = 1'b1;
		end
		timed_out = (cnt >= TMO_LAST);
	end

	always_comb begin
		next_state = state;
		next_cur = cur;
		next_cnt = cnt + 1'b1;
		next_req_ready = 1'b0;
		next_resp_valid = 1'b0;
		next_resp_error = resp_error;
		next_rdata = resp_rdata;
		unique case (state)
			ST_IDLE: begin
				next_cnt = '0;
				next_req_ready = 1'b1;
				if (req_valid && req_ready) begin
					next_cur = req;
					next_req_ready = 1'b0;
					next_state = (req.target == sbi_pkg::SBI_DRAM) ? ST_ROW : ST_SETUP;
				end
			end
			ST_ROW: begin
				if (cnt >= ROW_LAST) begin
					next_cnt = '0;
					next_state = ST_COL;
				end
			end
			ST_COL: begin
				if (cnt >= CAS_LAST) begin
					next_cnt = '0;
					next_state = ST_HOLD;
					next_rdata = data_in;
					next_resp_error = 1'b0;
				end
			end
			ST_SETUP: begin
				next_cnt = '0;
				next_state = ST_STROBE;
			end
			ST_STROBE: begin
				if ((cnt >= STB_LAST && go_on) || timed_out) begin
					next_cnt = '0;
					next_state = ST_HOLD;
					next_rdata = data_in;
					next_resp_error = timed_out && !go_on;
				end
			end
			ST_HOLD: begin
				next_resp_valid = 1'b1;
				next_req_ready = 1'b1;
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			cur <= '0;
			cnt <= '0;
			req_ready <= 1'b0;
			resp_valid <= 1'b0;
			resp_error <= 1'b0;
			resp_rdata <= '0;
		end else begin
			state <= next_state;
			cur <= next_cur;
			cnt <= next_cnt;
			req_ready <= next_req_ready;
			resp_valid <= next_resp_valid;
			resp_error <= next_resp_error;
			resp_rdata <= next_rdata;
		end
	end
	////////////////////////////////////////////////////////////////////
	// pin decode, registered from the next state
	sbi_pkg::sbi_pins_t pins, next_pins;
	logic rd, wr, act;

	always_comb begin
		next_pins = sbi_pkg::PINS_IDLE;
		rd = !next_cur.write;
		wr = next_cur.write;
		act = (next_state == ST_STROBE);
		if (next_state != ST_IDLE) begin
			// [RQ1] address on every access
			next_pins.addr = next_cur.addr;
			// [RQ2] [RQ21] drive data only on writes
			next_pins.data_oe = wr;
			next_pins.data_out = next_cur.wdata;
			unique case (next_cur.target)
				sbi_pkg::SBI_DRAM: begin
					// [RQ9] row strobe of chosen chip
					next_pins.dram_row_strobe_n[next_cur.chip] = (next_state == ST_HOLD);
					next_pins.addr = (next_state == ST_ROW)
						? sbi_pkg::ADDR_W'(next_cur.addr >> sbi_pkg::COL_W)
						: sbi_pkg::ADDR_W'(next_cur.addr[sbi_pkg::COL_W-1:0]);
					if (next_state == ST_COL) begin
						// [RQ10] column strobe per byte half
						next_pins.dram_upper_column_strobe_n = !next_cur.byte_en[1];
						next_pins.dram_lower_column_strobe_n = !next_cur.byte_en[0];
						// [RQ11] dram write enable
						next_pins.dram_write_enable_n = !wr;
					end
				end
				sbi_pkg::SBI_ROM: begin
					// [RQ7] one boot memory select
					next_pins.boot_memory_select_n[next_cur.chip] = 1'b0;
					// [RQ8] boot memory read enable
					next_pins.boot_memory_read_enable_n = !(act && rd);
					// [RQ5] strobe writes flash
					next_pins.shared_write_strobe_n = !(act && wr);
				end
				sbi_pkg::SBI_DISPLAY: begin
					// [RQ3] display select
					next_pins.display_select_n = 1'b0;
					// [RQ4] display read enable
					next_pins.display_read_enable_n = !(act && rd);
					// [RQ5] strobe writes display
					next_pins.shared_write_strobe_n = !(act && wr);
				end
				sbi_pkg::SBI_CARD_IO: begin
					// [RQ13] upper byte valid
					next_pins.card_high_byte_enable_n = !next_cur.byte_en[1];
					// [RQ14] card io read
					next_pins.card_io_read_n = !(act && rd);
					// [RQ15] card io write
					next_pins.card_io_write_n = !(act && wr);
				end
				sbi_pkg::SBI_CARD_MEM: begin
					// [RQ13] upper byte valid
					next_pins.card_high_byte_enable_n = !next_cur.byte_en[1];
					// [RQ16] card memory read
					next_pins.card_mem_read_n = !(act && rd);
					// [RQ17] card memory write
					next_pins.card_mem_write_n = !(act && wr);
				end
				default: begin
					next_pins.data_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pins <= sbi_pkg::PINS_IDLE;
		end else begin
			pins <= next_pins;
		end
	end

	assign addr_out = pins.addr;
	assign data_out = pins.data_out;
	assign data_oe = pins.data_oe;
	assign display_select_n = pins.display_select_n;
	assign display_read_enable_n = pins.display_read_enable_n;
	assign shared_write_strobe_n = pins.shared_write_strobe_n;
	assign boot_memory_select_n = pins.boot_memory_select_n;
	assign boot_memory_read_enable_n = pins.boot_memory_read_enable_n;
	assign dram_row_strobe_n = pins.dram_row_strobe_n;
	assign dram_upper_column_strobe_n = pins.dram_upper_column_strobe_n;
	assign dram_lower_column_strobe_n = pins.dram_lower_column_strobe_n;
	assign dram_write_enable_n = pins.dram_write_enable_n;
	assign card_high_byte_enable_n = pins.card_high_byte_enable_n;
	assign card_io_read_n = pins.card_io_read_n;
	assign card_io_write_n = pins.card_io_write_n;
	assign card_mem_read_n = pins.card_mem_read_n;
	assign card_mem_write_n = pins.card_mem_write_n;
	////////////////////////////////////////////////////////////////////
	// card clock and card reset
	logic [4:0] div, next_div;
	logic next_card_clock, next_card_reset;

	always_comb begin
		// [RQ12] divide core clock to card clock
		next_div = (div >= CARD_LAST) ? 5'h00 : div + 5'h01;
		next_card_clock = (next_div < CARD_HI);
		// [RQ20] reset the card controller
		next_card_reset = card_reset_req;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			div <= CARD_LAST;
			card_clock <= 1'b0;
			card_reset_out <= 1'b1;
		end else begin
			div <= next_div;
			card_clock <= next_card_clock;
			card_reset_out <= next_card_reset;
		end
	end
	////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_row_shown;
		!(&dram_row_strobe_n) && dram_upper_column_strobe_n && dram_lower_column_strobe_n;
	endsequence
	sequence s_col_shown;
		!(&dram_row_strobe_n) && !(dram_upper_column_strobe_n && dram_lower_column_strobe_n);
	endsequence

	addr_hold_a: assert property ( // [RQ1]
		state == ST_STROBE && $past(state) == ST_STROBE |-> $stable(addr_out))
		else $error("address moved during strobe");
	data_drive_a: assert property ( // [RQ21]
		data_oe |-> cur.write && state != ST_IDLE)
		else $error("data bus driven outside a write");
	display_read_a: assert property ( // [RQ4]
		!display_read_enable_n |-> !display_select_n && !cur.write)
		else $error("display read enable without display read");
	one_group_a: assert property ( // [RQ21]
		$onehot0({!display_select_n, !(&boot_memory_select_n), !(&dram_row_strobe_n),
			!card_high_byte_enable_n || !card_io_read_n || !card_io_write_n
			|| !card_mem_read_n || !card_mem_write_n}))
		else $error("two targets selected at once");
	boot_select_a: assert property ( // [RQ7]
		$countones(~boot_memory_select_n) <= 1)
		else $error("more than one boot memory select");
	dram_order_a: assert property ( // [RQ9]
		req_valid && req_ready && req.target == sbi_pkg::SBI_DRAM
		|=> s_row_shown ##[1:8] s_col_shown)
		else $error("dram row then column order broken");
	card_clock_a: assert property ( // [RQ12]
		$rose(card_clock) |-> ##25 $rose(card_clock))
		else $error("card clock period wrong");
	card_reset_a: assert property ( // [RQ20]
		card_reset_req |=> card_reset_out)
		else $error("card reset not asserted");
	dram_write_a: assert property ( // [RQ11]
		!dram_write_enable_n |-> cur.target == sbi_pkg::SBI_DRAM && cur.write)
		else $error("dram write enable outside dram write");
	strobe_wait_a: assert property ( // [RQ6]
		state == ST_STROBE && next_state == ST_HOLD && cur.target == sbi_pkg::SBI_DISPLAY
		|-> ready_s || timed_out)
		else $error("display access ended without ready");
endmodule
`default_nettype wire

// >>> common/sbi_pkg.sv
// shared types and constants of the external system bus port
// assumes a 200 MHz core clock and one access at a time on the pins
// Function
// [RQ1] drive the 21-bit address bus on every access
// [RQ2] 16-bit data bus, driven by us on writes, by the target on reads
// [RQ3] display select low whenever the display is accessed
// [RQ4] display read enable low while reading the display
// [RQ5] shared write strobe writes display when selected, else flash
// [RQ6] target ready input lets a display or card access proceed
// [RQ7] four boot memory selects, only the addressed chip goes low
// [RQ8] boot memory read enable low while reading boot memory
// [RQ9] row strobe of the chosen dram chip low while row address shown
// [RQ10] upper or lower column strobe low with column address per byte half
// [RQ11] dram write enable low while writing dram
// [RQ12] continuous 8 MHz card clock output
// [RQ13] card high byte enable low when the upper data byte is valid
// [RQ14] card io read strobe low during card io reads
// [RQ15] card io write strobe low during card io writes
// [RQ16] card memory read strobe low during card memory reads
// [RQ17] card memory write strobe low during card memory writes
// [RQ18] card zero wait input low ends a card access without waits
// [RQ19] card interrupt input is taken as an interrupt request
// [RQ20] card reset output high while the card controller is reset
// [RQ21] one target group per access; data bus driven only on writes
package sbi_pkg;
	localparam int ADDR_W = 21;
	localparam int DATA_W = 16;
	localparam int CHIPS = 4;
	localparam int CLK_MHZ = 200;
	localparam int CARD_MHZ = 8;
	// card clock period in core cycles, high for the shorter half
	localparam int CARD_DIV = CLK_MHZ / CARD_MHZ;
	localparam int CARD_HIGH = CARD_DIV / 2;
	// least row strobe time before column, and least strobe widths
	localparam int T_ROW_NS = 20;
	localparam int T_CAS_NS = 20;
	localparam int T_STROBE_NS = 30;
	localparam int ROW_CYC = (T_ROW_NS * CLK_MHZ + 999) / 1000;
	localparam int CAS_CYC = (T_CAS_NS * CLK_MHZ + 999) / 1000;
	localparam int STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
	// dram address split: low bits are the column
	localparam int COL_W = 10;
	localparam int TIMEOUT_CYC = 255;
	localparam int CNT_W = 8;

	typedef enum logic [2:0] {
		SBI_DRAM,
		SBI_ROM,
		SBI_DISPLAY,
		SBI_CARD_IO,
		SBI_CARD_MEM
	} sbi_target_t;

	typedef struct packed {
		sbi_target_t target;
		logic write;
		logic [1:0] chip;
		logic [1:0] byte_en;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} sbi_req_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data_out;
		logic data_oe;
		logic display_select_n;
		logic display_read_enable_n;
		logic shared_write_strobe_n;
		logic [CHIPS-1:0] boot_memory_select_n;
		logic boot_memory_read_enable_n;
		logic [CHIPS-1:0] dram_row_strobe_n;
		logic dram_upper_column_strobe_n;
		logic dram_lower_column_strobe_n;
		logic dram_write_enable_n;
		logic card_high_byte_enable_n;
		logic card_io_read_n;
		logic card_io_write_n;
		logic card_mem_read_n;
		logic card_mem_write_n;
	} sbi_pins_t;

	localparam sbi_pins_t PINS_IDLE = '{
		addr: '0, data_out: '0, data_oe: 1'b0,
		display_select_n: 1'b1, display_read_enable_n: 1'b1,
		shared_write_strobe_n: 1'b1, boot_memory_select_n: 4'hf,
		boot_memory_read_enable_n: 1'b1, dram_row_strobe_n: 4'hf,
		dram_upper_column_strobe_n: 1'b1, dram_lower_column_strobe_n: 1'b1,
		dram_write_enable_n: 1'b1, card_high_byte_enable_n: 1'b1,
		card_io_read_n: 1'b1, card_io_write_n: 1'b1,
		card_mem_read_n: 1'b1, card_mem_write_n: 1'b1};
endpackage

// >>> hw/sbi_pin_sync.sv
// three-stage synchroniser for pin inputs
// a change is taken once the second and third stages agree
`timescale 1ns/10ps
`default_nettype none
module sbi_pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// pins and filtered levels
	input wire logic [W-1:0] pin,
	output logic [W-1:0] level
);
	logic [W-1:0] s1, s2, s3;
	logic [W-1:0] next_level;

	always_comb begin
		next_level = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & level);
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s1 <= RESET_VAL;
			s2 <= RESET_VAL;
			s3 <= RESET_VAL;
			level <= RESET_VAL;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			level <= next_level;
		end
	end
endmodule
`default_nettype wire

// >>> tb/sbi_far_model.sv
// far side of the bus port: memory chips, display and card controller
// assumes the bench resolves the data wire from both drivers
`timescale 1ns/10ps
`default_nettype none
module sbi_far_model (
	// clock
	input wire logic mclk,
	// pins from the port, strobes packed by the bench
	input wire logic [20:0] addr_out,
	input wire logic [15:0] bus,
	input wire logic [19:0] pins_n,
	// bench controls
	input wire logic [7:0] delay,
	input wire logic zw_en,
	input wire logic irq_cmd,
	// answers to the port
	output logic [15:0] rd_data,
	output logic rd_oe,
	output logic target_ready,
	output logic card_zero_wait_n,
	output logic card_irq,
	output logic [15:0] wr_data
);
	logic [7:0] cnt = 8'h00;
	logic slow;
	logic rdy;
	assign rd_oe = !pins_n[7] || !pins_n[5] || !pins_n[3] || !pins_n[1]
		|| (pins_n[9] && !(pins_n[11] && pins_n[10]));
	assign rd_data = addr_out[15:0] ^ 16'ha5c3;
	assign slow = !(pins_n[8] && pins_n[3:0] == 4'hf);
	assign rdy = slow && cnt >= delay && delay != 8'hff;
	assign target_ready = rdy && !zw_en;
	assign card_zero_wait_n = !(rdy && zw_en);
	assign card_irq = irq_cmd;
	always @(posedge mclk) begin
		cnt <= slow ? cnt + 8'h01 : 8'h00;
		if (!(pins_n[9] && pins_n[6] && pins_n[2] && pins_n[0]))
			wr_data <= bus;
	end
endmodule
`default_nettype wire

// >>> tb/test_system_bus_interface.sv
// bench of the system bus port: far-side model, one task per scenario
// assumes the port runs one access at a time on a 200 MHz clock
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module test_system_bus_interface;
	localparam int TMO = 20;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic req_valid = 1'b0;
	logic card_reset_req = 1'b0;
	logic zw_en = 1'b0;
	logic irq_cmd = 1'b0;
	logic [7:0] delay = 8'h00;
	sbi_pkg::sbi_req_t req = '0;
	logic req_ready, resp_valid, resp_error, card_irq_req, data_oe, card_clock;
	logic card_reset_out, rd_oe, target_ready, card_zero_wait_n, card_irq;
	logic [15:0] resp_rdata, data_out, rd_data, wr_data;
	logic [15:0] last_bus = 16'h0000;
	logic [20:0] addr_out;
	logic [20:0] g_seen;
	wire [19:0] pn;
	wire [15:0] bus = data_oe ? data_out : (rd_oe ? rd_data : ~last_bus);
	int error_cnt = 0;
	int num_checks = 0;
	int cyc = 0;
	int g_lat;
	////////////////////////////////////////////////////////////////
	always #2.5 mclk = ~mclk;
	always @(posedge mclk) last_bus <= bus;
	sbi_bus_port #(.TIMEOUT_CYC(TMO)) i_sbi_bus_port (.mclk(mclk), .rst(rst),
		.req_valid(req_valid), .req(req), .req_ready(req_ready), .resp_valid(resp_valid),
		.resp_error(resp_error), .resp_rdata(resp_rdata), .card_reset_req(card_reset_req),
		.card_irq_req(card_irq_req), .addr_out(addr_out), .data_in(bus),
		.data_out(data_out), .data_oe(data_oe), .display_select_n(pn[8]),
		.display_read_enable_n(pn[7]), .shared_write_strobe_n(pn[6]),
		.target_ready(target_ready), .boot_memory_select_n(pn[19:16]),
		.boot_memory_read_enable_n(pn[5]), .dram_row_strobe_n(pn[15:12]),
		.dram_upper_column_strobe_n(pn[11]), .dram_lower_column_strobe_n(pn[10]),
		.dram_write_enable_n(pn[9]), .card_clock(card_clock),
		.card_high_byte_enable_n(pn[4]), .card_io_read_n(pn[3]), .card_io_write_n(pn[2]),
		.card_mem_read_n(pn[1]), .card_mem_write_n(pn[0]),
		.card_zero_wait_n(card_zero_wait_n), .card_irq(card_irq),
		.card_reset_out(card_reset_out));
	sbi_far_model i_sbi_far_model (.mclk(mclk), .addr_out(addr_out), .bus(bus),
		.pins_n(pn), .delay(delay), .zw_en(zw_en), .irq_cmd(irq_cmd), .rd_data(rd_data),
		.rd_oe(rd_oe), .target_ready(target_ready), .card_zero_wait_n(card_zero_wait_n),
		.card_irq(card_irq), .wr_data(wr_data));
	////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			close_out();
		end
	end
	// strobes expected low at some cycle of an access; bit 20 low if data was driven
	function automatic logic [20:0] exp_pins(sbi_pkg::sbi_req_t r);
		logic [20:0] e;
		e = '1;
		e[20] = !r.write;
		case (r.target)
			sbi_pkg::SBI_ROM: begin
				e[16 + r.chip] = 1'b0;
				e[r.write ? 6 : 5] = 1'b0;
			end
			sbi_pkg::SBI_DRAM: begin
				e[12 + r.chip] = 1'b0;
				e[11:10] = ~r.byte_en;
				e[9] = !r.write;
			end
			sbi_pkg::SBI_DISPLAY: begin
				e[8] = 1'b0;
				e[r.write ? 6 : 7] = 1'b0;
			end
			sbi_pkg::SBI_CARD_IO: begin
				e[4] = !r.byte_en[1];
				e[r.write ? 2 : 3] = 1'b0;
			end
			default: begin
				e[4] = !r.byte_en[1];
				e[r.write ? 0 : 1] = 1'b0;
			end
		endcase
		return e;
	endfunction
	task automatic op(sbi_pkg::sbi_target_t t, logic w, logic [1:0] c, logic [1:0] be,
		logic [20:0] a, logic [15:0] d, logic e);
		sbi_pkg::sbi_req_t r;
		logic [15:0] x;
		int n;
		r = '{target: t, write: w, chip: c, byte_en: be, addr: a, wdata: d};
		n = 0;
		while (req_ready !== 1'b1 && n < 50)
			@(posedge mclk) n++;
		req <= r;
		req_valid <= 1'b1;
		@(posedge mclk);
		req_valid <= 1'b0;
		g_seen = '1;
		g_lat = -1;
		do begin
			@(posedge mclk);
			g_lat++;
			g_seen &= {~data_oe, pn};
		end while (resp_valid !== 1'b1 && g_lat < 300);
		x = (t == sbi_pkg::SBI_DRAM) ? {6'h00, a[9:0]} : a[15:0];
		`CHK(g_seen, exp_pins(r))
		`CHK(resp_error, e)
		if (w)
			`CHK(wr_data, d)
		else if (!e)
			`CHK(resp_rdata, x ^ 16'ha5c3)
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_rom();
		for (int c = 0; c < 4; c++) begin
			op(sbi_pkg::SBI_ROM, 1'b0, 2'(c), 2'b11, 21'h1abc0 + 21'(c * 3), 16'h0000, 1'b0);
			`CHK(g_lat, sbi_pkg::STROBE_CYC + 2)
		end
		op(sbi_pkg::SBI_ROM, 1'b1, 2'd1, 2'b11, 21'h1f0f0, 16'hbeef, 1'b0);
	endtask
	task automatic t_dram();
		for (int i = 0; i < 6; i++) begin
			op(sbi_pkg::SBI_DRAM, 1'(i & 1), 2'(i), 2'(i / 2 + 1), 21'h155aa + 21'(i * 5),
				16'h1234 + 16'(i), 1'b0);
			`CHK(g_lat, sbi_pkg::ROW_CYC + sbi_pkg::CAS_CYC + 1)
		end
	endtask
	task automatic t_display();
		int fast;
		op(sbi_pkg::SBI_DISPLAY, 1'b0, 2'd0, 2'b11, 21'h0c0de, 16'h0000, 1'b0);
		fast = g_lat;
		delay <= 8'd10;
		op(sbi_pkg::SBI_DISPLAY, 1'b0, 2'd0, 2'b11, 21'h0c0df, 16'h0000, 1'b0);
		`CHK(g_lat >= fast + 5, 1'b1)
		op(sbi_pkg::SBI_DISPLAY, 1'b1, 2'd3, 2'b11, 21'h0c0e0, 16'h5aa5, 1'b0);
		delay <= 8'd0;
	endtask
	task automatic t_card();
		zw_en <= 1'b1;
		for (int i = 0; i < 8; i++)
			op(i < 4 ? sbi_pkg::SBI_CARD_IO : sbi_pkg::SBI_CARD_MEM, 1'(i & 1), 2'd0,
				(i & 2) ? 2'b10 : 2'b01, 21'h03000 + 21'(i), 16'h8001 + 16'(i), 1'b0);
		zw_en <= 1'b0;
		op(sbi_pkg::SBI_CARD_MEM, 1'b0, 2'd0, 2'b11, 21'h03100, 16'h0000, 1'b0);
	endtask
	task automatic t_timeout();
		delay <= 8'hff;
		op(sbi_pkg::SBI_DISPLAY, 1'b0, 2'd0, 2'b11, 21'h0c100, 16'h0000, 1'b1);
		zw_en <= 1'b1;
		op(sbi_pkg::SBI_CARD_IO, 1'b1, 2'd0, 2'b10, 21'h03200, 16'h7e7e, 1'b1);
		zw_en <= 1'b0;
		delay <= 8'h00;
	endtask
	task automatic t_clock();
		int hi;
		int lo;
		int n;
		hi = 0;
		lo = 0;
		n = 0;
		while (card_clock !== 1'b0 && n < 60)
			@(posedge mclk) n++;
		while (card_clock !== 1'b1 && n < 60)
			@(posedge mclk) n++;
		while (card_clock === 1'b1 && hi < 60)
			@(posedge mclk) hi++;
		while (card_clock === 1'b0 && lo < 60)
			@(posedge mclk) lo++;
		`CHK(hi, sbi_pkg::CARD_HIGH)
		`CHK(lo, sbi_pkg::CARD_DIV - sbi_pkg::CARD_HIGH)
	endtask
	task automatic t_ctl();
		card_reset_req <= 1'b1;
		repeat (2) @(posedge mclk);
		`CHK(card_reset_out, 1'b1)
		card_reset_req <= 1'b0;
		repeat (2) @(posedge mclk);
		`CHK(card_reset_out, 1'b0)
		irq_cmd <= 1'b1;
		repeat (6) @(posedge mclk);
		`CHK(card_irq_req, 1'b1)
		irq_cmd <= 1'b0;
		repeat (6) @(posedge mclk);
		`CHK(card_irq_req, 1'b0)
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge mclk);
		`CHK(card_reset_out, 1'b1)
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		t_rom();
		t_dram();
		t_display();
		t_card();
		t_timeout();
		t_clock();
		t_ctl();
		close_out();
	end
endmodule
`undef CHK
`default_nettype wire
